// ---- rtl/hdavh_params.svh ----
// Constants of the widget verb handler: node ids, verb codes, reset values
`ifndef HDAVH_PARAMS_SVH
`define HDAVH_PARAMS_SVH

// ----------------------------------------------------------------
// Node identifiers
// ----------------------------------------------------------------
`define HDAVH_NID_ROOT 8'h00
`define HDAVH_NID_AFG 8'h01
`define HDAVH_NID_SPDIF 8'h02
`define HDAVH_NID_FRONT 8'h03
`define HDAVH_NID_SURR 8'h04

// ----------------------------------------------------------------
// Verb codes (12-bit verbs with 8-bit payload, 4-bit with 16-bit)
// ----------------------------------------------------------------
`define HDAVH_VERB_SET_SDI 12'h704
`define HDAVH_VERB_GET_SDI 12'hf04
`define HDAVH_VERB_SET_PST 12'h703
`define HDAVH_VERB_GET_PST 12'hf03
`define HDAVH_VERB_SET_CONN 12'h701
`define HDAVH_VERB_GET_CONN 12'hf01
`define HDAVH_VERB4_SET_COEF 4'h4
`define HDAVH_VERB4_SET_CIDX 4'h5
`define HDAVH_VERB4_GET_COEF 4'hc
`define HDAVH_VERB4_GET_CIDX 4'hd

// ----------------------------------------------------------------
// Field positions, sizes and reset values
// ----------------------------------------------------------------
`define HDAVH_PST_SYM_BIT 7
`define HDAVH_PST_BENIGN_BIT 1
`define HDAVH_CIDX_CH_BIT 6
`define HDAVH_VF_COUNT 16
`define HDAVH_EQ_DEPTH 128
`define HDAVH_CIDX_RESET 8'h00
`define HDAVH_COEF_RESET 16'h0000
`define HDAVH_BYPASS_RESET 1'b1
`define HDAVH_SYM_RESET 1'b1
`define HDAVH_SPDIF_SRC_RESET 1'b0

`endif

// ---- rtl/hdavh_pkg.sv ----
// Types shared by the widget verb handler
package hdavh_pkg;
  typedef enum logic [1:0] {
    HDAVH_LK_IDLE,
    HDAVH_LK_WAIT,
    HDAVH_LK_RESP
  } hdavh_lk_e;

  typedef enum logic [3:0] {
    HDAVH_CMD_NONE,
    HDAVH_CMD_SET_SDI,
    HDAVH_CMD_GET_SDI,
    HDAVH_CMD_SET_PST,
    HDAVH_CMD_GET_PST,
    HDAVH_CMD_SET_CONN,
    HDAVH_CMD_GET_CONN,
    HDAVH_CMD_SET_COEF,
    HDAVH_CMD_GET_COEF,
    HDAVH_CMD_SET_CIDX,
    HDAVH_CMD_GET_CIDX
  } hdavh_cmd_e;
endpackage : hdavh_pkg

// ---- rtl/hdavh_sync2.sv ----
// Two flip-flop synchroniser for one level
`timescale 1ns/1ps
module hdavh_sync2 (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic ce,
  input wire logic d,
  output logic q
);
  logic meta;

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      meta <= 1'b0;
      q <= 1'b0;
    end else if (ce) begin
      meta <= d;
      q <= meta;
    end
  end
endmodule : hdavh_sync2

// ---- rtl/hdavh_widget_verb_handler.sv ----
// Verb handler for the root, function group and first converter widgets
`timescale 1ns/1ps
`include "hdavh_params.svh"

module hdavh_widget_verb_handler import hdavh_pkg::*; (
  input wire logic mclk,
  input wire logic rst_n,
  input wire logic ce,
  input wire logic bit_clk,
  input wire logic cmd_valid,
  input wire logic [31:0] cmd_word,
  output logic cmd_ready,
  output logic resp_valid,
  output logic [31:0] resp_word,
  input wire logic [6:0] eq_rd_addr,
  output logic [15:0] eq_coef_data,
  output logic eq_bypass,
  output logic symmetric_coeff,
  output logic spdif_src_adc
);

  // ----------------------------------------------------------------
  // Verb decode
  // ----------------------------------------------------------------
  function automatic hdavh_cmd_e hdavh_decode(input logic [19:0] v);
    hdavh_cmd_e c;
    case (v[19:8])
      `HDAVH_VERB_SET_SDI: c = HDAVH_CMD_SET_SDI;
      `HDAVH_VERB_GET_SDI: c = HDAVH_CMD_GET_SDI;
      `HDAVH_VERB_SET_PST: c = HDAVH_CMD_SET_PST;
      `HDAVH_VERB_GET_PST: c = HDAVH_CMD_GET_PST;
      `HDAVH_VERB_SET_CONN: c = HDAVH_CMD_SET_CONN;
      `HDAVH_VERB_GET_CONN: c = HDAVH_CMD_GET_CONN;
      default: begin
        case (v[19:16])
          `HDAVH_VERB4_SET_COEF: c = HDAVH_CMD_SET_COEF;
          `HDAVH_VERB4_GET_COEF: c = HDAVH_CMD_GET_COEF;
          `HDAVH_VERB4_SET_CIDX: c = HDAVH_CMD_SET_CIDX;
          `HDAVH_VERB4_GET_CIDX: c = HDAVH_CMD_GET_CIDX;
          default: c = HDAVH_CMD_NONE;
        endcase
      end
    endcase
    return c;
  endfunction : hdavh_decode

  // ----------------------------------------------------------------
  // Declarations
  // ----------------------------------------------------------------
  logic rst_a, rst_q, lrst_a, lrst;
  hdavh_lk_e lk_state;
  logic [31:0] cmd_hold, resp_hold, next_resp;
  logic req_tgl, req_s, req_last, ack_tgl, ack_s, ack_last;
  hdavh_cmd_e cmd;
  logic exec, at_afg, at_spdif, at_front, at_surr, eq_wr;
  logic [7:0] nid, pay8, vf_idx, eq_idx, pstate_val;
  logic [15:0] pay16, vf_rd;
  logic [15:0] vf_mem [`HDAVH_VF_COUNT];
  logic [15:0] eq_mem [`HDAVH_EQ_DEPTH];

  // ----------------------------------------------------------------
  // Reset release in both domains
  // ----------------------------------------------------------------
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      rst_a <= 1'b0;
      rst_q <= 1'b0;
    end else begin
      rst_a <= 1'b1;
      rst_q <= rst_a;
    end
  end

  always_ff @(posedge bit_clk or negedge rst_n) begin
    if (!rst_n) begin
      lrst_a <= 1'b0;
      lrst <= 1'b0;
    end else begin
      lrst_a <= 1'b1;
      lrst <= lrst_a;
    end
  end

  // ----------------------------------------------------------------
  // Link side: take one verb, hold it, return its response
  // ----------------------------------------------------------------
  hdavh_sync2 u_ack_sync (
    .clk(bit_clk),
    .rst_n(lrst),
    .ce(1'b1),
    .d(ack_tgl),
    .q(ack_s)
  );

  always_ff @(posedge bit_clk or negedge lrst) begin
    if (!lrst) begin
      lk_state <= HDAVH_LK_IDLE;
      cmd_ready <= 1'b0;
    end else begin
      case (lk_state)
        HDAVH_LK_IDLE: begin
          cmd_ready <= 1'b1;
          if (cmd_valid && cmd_ready) begin
            cmd_ready <= 1'b0;
            lk_state <= HDAVH_LK_WAIT;
          end
        end
        HDAVH_LK_WAIT: begin
          if (ack_s != ack_last) begin
            lk_state <= HDAVH_LK_RESP;
          end
        end
        HDAVH_LK_RESP: begin
          cmd_ready <= 1'b1;
          lk_state <= HDAVH_LK_IDLE;
        end
        default: begin
          lk_state <= HDAVH_LK_IDLE;
        end
      endcase
    end
  end

  // Held word stays stable until the core acknowledges it
  always_ff @(posedge bit_clk or negedge lrst) begin
    if (!lrst) begin
      cmd_hold <= 32'h0000_0000;
      req_tgl <= 1'b0;
    end else if (lk_state == HDAVH_LK_IDLE && cmd_valid && cmd_ready) begin
      cmd_hold <= cmd_word;
      req_tgl <= ~req_tgl;
    end
  end

  always_ff @(posedge bit_clk or negedge lrst) begin
    if (!lrst) begin
      ack_last <= 1'b0;
      resp_valid <= 1'b0;
      resp_word <= 32'h0000_0000;
    end else begin
      resp_valid <= 1'b0;
      if (lk_state == HDAVH_LK_WAIT && ack_s != ack_last) begin
        ack_last <= ack_s;
        resp_valid <= 1'b1;
        resp_word <= resp_hold;
      end
    end
  end

  // ----------------------------------------------------------------
  // Core side: detect a new verb and route it by node
  // ----------------------------------------------------------------
  hdavh_sync2 u_req_sync (
    .clk(mclk),
    .rst_n(rst_q),
    .ce(ce),
    .d(req_tgl),
    .q(req_s)
  );

  assign exec = ce && (req_s != req_last);
  assign cmd = hdavh_decode(cmd_hold[19:0]);
  assign nid = cmd_hold[27:20];
  assign pay8 = cmd_hold[7:0];
  assign pay16 = cmd_hold[15:0];
  assign at_afg = (nid == `HDAVH_NID_AFG);
  assign at_spdif = (nid == `HDAVH_NID_SPDIF);
  assign at_front = (nid == `HDAVH_NID_FRONT);
  assign at_surr = (nid == `HDAVH_NID_SURR);

  always_ff @(posedge mclk or negedge rst_q) begin
    if (!rst_q) begin
      req_last <= 1'b0;
      ack_tgl <= 1'b0;
      resp_hold <= 32'h0000_0000;
    end else if (exec) begin
      req_last <= req_s;
      ack_tgl <= ~ack_tgl;
      resp_hold <= next_resp;
    end
  end

  // ----------------------------------------------------------------
  // Responses
  // ----------------------------------------------------------------
  assign vf_rd = (vf_idx < 8'(`HDAVH_VF_COUNT)) ? vf_mem[vf_idx[3:0]] : 16'h0000;
  assign pstate_val = {~symmetric_coeff, 5'h00, ~eq_bypass, 1'b0};

  always_comb begin
    next_resp = 32'h0000_0000;
    case (cmd)
      HDAVH_CMD_GET_COEF: begin
        if (at_afg) begin
          next_resp = {16'h0000, vf_rd};
        end else if (at_front) begin
          next_resp = {16'h0000, eq_mem[eq_idx[6:0]]};
        end
      end
      HDAVH_CMD_GET_CIDX: begin
        next_resp = {24'h0, at_afg ? vf_idx : (at_front ? eq_idx : 8'h00)};
      end
      HDAVH_CMD_GET_PST: next_resp = at_front ? {24'h0, pstate_val} : 32'h0;
      HDAVH_CMD_GET_CONN: next_resp = at_spdif ? {31'h0, spdif_src_adc} : 32'h0;
      default: begin
        next_resp = 32'h0000_0000;
      end
    endcase
  end

  // ----------------------------------------------------------------
  // Function group vendor functions
  // ----------------------------------------------------------------
  always_ff @(posedge mclk or negedge rst_q) begin
    if (!rst_q) begin
      vf_idx <= `HDAVH_CIDX_RESET;
    end else if (exec && at_afg && cmd == HDAVH_CMD_SET_CIDX) begin
      vf_idx <= pay8;
    end
  end

  generate
    for (genvar g = 0; g < `HDAVH_VF_COUNT; g++) begin : g_vf
      always_ff @(posedge mclk or negedge rst_q) begin
        if (!rst_q) begin
          vf_mem[g] <= `HDAVH_COEF_RESET;
        end else if (exec && at_afg && cmd == HDAVH_CMD_SET_COEF &&
                     vf_idx == 8'(g)) begin
          vf_mem[g] <= pay16;
        end
      end
    end
  endgenerate

  // ----------------------------------------------------------------
  // Front DAC equalizer storage
  // ----------------------------------------------------------------
  always_ff @(posedge mclk or negedge rst_q) begin
    if (!rst_q) begin
      eq_idx <= `HDAVH_CIDX_RESET;
    end else if (exec && at_front && cmd == HDAVH_CMD_SET_CIDX) begin
      eq_idx <= pay8;
    end
  end

  // Writes land whatever the processing state is
  assign eq_wr = exec && at_front && cmd == HDAVH_CMD_SET_COEF;

  always_ff @(posedge mclk or negedge rst_q) begin
    if (!rst_q) begin
      for (int i = 0; i < `HDAVH_EQ_DEPTH; i++) begin
        eq_mem[i] <= `HDAVH_COEF_RESET;
      end
    end else if (eq_wr) begin
      for (int ch = 0; ch < 2; ch++) begin
        if (symmetric_coeff || eq_idx[`HDAVH_CIDX_CH_BIT] == 1'(ch)) begin
          eq_mem[{1'(ch), eq_idx[5:0]}] <= pay16;
        end
      end
    end
  end

  always_ff @(posedge mclk or negedge rst_q) begin
    if (!rst_q) begin
      eq_coef_data <= `HDAVH_COEF_RESET;
    end else if (ce) begin
      eq_coef_data <= eq_mem[eq_rd_addr];
    end
  end

  // ----------------------------------------------------------------
  // Processing state and converter controls
  // ----------------------------------------------------------------
  always_ff @(posedge mclk or negedge rst_q) begin
    if (!rst_q) begin
      eq_bypass <= `HDAVH_BYPASS_RESET;
      symmetric_coeff <= `HDAVH_SYM_RESET;
    end else if (exec && at_front && cmd == HDAVH_CMD_SET_PST) begin
      eq_bypass <= (pay8[6:0] == 7'h00);
      symmetric_coeff <= ~pay8[`HDAVH_PST_SYM_BIT];
    end
  end

  always_ff @(posedge mclk or negedge rst_q) begin
    if (!rst_q) begin
      spdif_src_adc <= `HDAVH_SPDIF_SRC_RESET;
    end else if (exec && at_spdif && cmd == HDAVH_CMD_SET_CONN) begin
      spdif_src_adc <= pay8[0];
    end
  end

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  a_sdi_get_zero: assert property (
    @(posedge mclk) disable iff (!rst_q)
    exec && cmd == HDAVH_CMD_GET_SDI |=> resp_hold == 32'h0000_0000
  ) else $error("SDI select get did not answer zero");
  a_afg_state_zero: assert property (
    @(posedge mclk) disable iff (!rst_q)
    exec && at_afg && cmd == HDAVH_CMD_GET_PST |=> resp_hold == 32'h0000_0000
  ) else $error("Function group state get did not answer zero");
  a_set_resp_zero: assert property (
    @(posedge mclk) disable iff (!rst_q)
    exec && cmd inside {HDAVH_CMD_SET_SDI, HDAVH_CMD_SET_PST, HDAVH_CMD_SET_COEF,
                        HDAVH_CMD_SET_CIDX, HDAVH_CMD_SET_CONN}
    |=> resp_hold == 32'h0000_0000
  ) else $error("Set verb gave a nonzero response");
  a_index_hold: assert property (
    @(posedge mclk) disable iff (!rst_q)
    exec && cmd == HDAVH_CMD_SET_COEF |=> $stable(vf_idx) && $stable(eq_idx)
  ) else $error("Coefficient index moved on a coefficient write");
  a_bypass_off: assert property (
    @(posedge mclk) disable iff (!rst_q)
    exec && at_front && cmd == HDAVH_CMD_SET_PST
    |=> eq_bypass == ($past(pay8) inside {8'h00, 8'h80})
  ) else $error("Equalizer bypass does not follow processing state");
  a_sym_inverse: assert property (
    @(posedge mclk) disable iff (!rst_q)
    exec && at_front && cmd == HDAVH_CMD_SET_PST
    |=> symmetric_coeff == !$past(cmd_hold[7])
  ) else $error("Symmetry is not the inverse of state bit 7");
  a_state_read: assert property (
    @(posedge mclk) disable iff (!rst_q)
    exec && at_front && cmd == HDAVH_CMD_GET_PST
    |=> resp_hold[7:0] == {!symmetric_coeff, 5'h00, !eq_bypass, 1'b0}
  ) else $error("Processing state read is not off or benign");
  a_sym_mirror: assert property (
    @(posedge mclk) disable iff (!rst_q)
    eq_wr && symmetric_coeff
    |=> eq_mem[{1'b0, eq_idx[5:0]}] == eq_mem[{1'b1, eq_idx[5:0]}]
  ) else $error("Symmetric load did not reach both channels");
  a_reset_state: assert property (
    @(posedge mclk) disable iff (!rst_q)
    $rose(rst_q) |-> eq_bypass && symmetric_coeff
  ) else $error("Processing state not 0x00 after reset");
  a_surr_zero: assert property (
    @(posedge mclk) disable iff (!rst_q)
    exec && at_surr |=> resp_hold == 32'h0000_0000
  ) else $error("Surround converter gave a nonzero response");
  a_resp_pulse: assert property (
    @(posedge bit_clk) disable iff (!lrst)
    resp_valid |=> !resp_valid && cmd_ready
  ) else $error("Response strobe longer than one link cycle");

endmodule : hdavh_widget_verb_handler

// ---- dv/hdavh_host_model.sv ----
// Link controller model: makes the link clock and issues one verb at a time
`timescale 1ns/1ps
module hdavh_host_model (
  output logic bit_clk,
  output logic cmd_valid,
  output logic [31:0] cmd_word,
  input wire logic cmd_ready,
  input wire logic resp_valid,
  input wire logic [31:0] resp_word
);
  // ----------------------------------------------------------------
  // Link clock, phase unrelated to the core clock
  // ----------------------------------------------------------------
  initial begin
    bit_clk = 1'b0;
    cmd_valid = 1'b0;
    cmd_word = 32'h0000_0000;
    #37;
    forever #62.5 bit_clk = ~bit_clk;
  end

  // ----------------------------------------------------------------
  // One verb: hold until taken, then wait for the answer
  // ----------------------------------------------------------------
  task automatic xfer(input logic [31:0] word, output logic [31:0] resp, output bit ok);
    int n;
    ok = 1'b0;
    resp = 32'h0000_0000;
    @(posedge bit_clk);
    cmd_valid <= 1'b1;
    cmd_word <= word;
    n = 0;
    do begin
      @(posedge bit_clk);
      n++;
    end while (cmd_ready !== 1'b1 && n < 40);
    // Released word shows its inverse so a stale value cannot pass
    cmd_valid <= 1'b0;
    cmd_word <= ~word;
    if (n >= 40) return;
    n = 0;
    do begin
      @(posedge bit_clk);
      n++;
    end while (resp_valid !== 1'b1 && n < 40);
    if (n >= 40) return;
    resp = resp_word;
    ok = 1'b1;
  endtask : xfer
endmodule : hdavh_host_model

// ---- dv/tb_top.sv ----
// Self-checking bench for the widget verb handler
`timescale 1ns/1ps
`include "hdavh_params.svh"
module tb_top;
  logic mclk;
  logic rst_n;
  logic ce;
  logic bit_clk;
  logic cmd_valid;
  logic [31:0] cmd_word;
  logic cmd_ready;
  logic resp_valid;
  logic [31:0] resp_word;
  logic [6:0] eq_rd_addr;
  logic [15:0] eq_coef_data;
  logic eq_bypass;
  logic symmetric_coeff;
  logic spdif_src_adc;
  int num_errors = 0;
  int checks = 0;

  hdavh_widget_verb_handler uut (
    .mclk(mclk), .rst_n(rst_n), .ce(ce), .bit_clk(bit_clk),
    .cmd_valid(cmd_valid), .cmd_word(cmd_word), .cmd_ready(cmd_ready),
    .resp_valid(resp_valid), .resp_word(resp_word), .eq_rd_addr(eq_rd_addr),
    .eq_coef_data(eq_coef_data), .eq_bypass(eq_bypass),
    .symmetric_coeff(symmetric_coeff), .spdif_src_adc(spdif_src_adc)
  );

  hdavh_host_model host (
    .bit_clk(bit_clk), .cmd_valid(cmd_valid), .cmd_word(cmd_word),
    .cmd_ready(cmd_ready), .resp_valid(resp_valid), .resp_word(resp_word)
  );

  initial mclk = 1'b0;
  always #50 mclk = ~mclk;

  // ----------------------------------------------------------------
  // Shared tasks
  // ----------------------------------------------------------------
  task automatic finish_test;
    $display("checks %0d errors %0d", checks, num_errors);
    if (num_errors == 0 && checks > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask : finish_test

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    checks++;
    if (seen !== exp) begin
      num_errors++;
      $display("BAD %0t seen %h expected %h", $time, seen, exp);
    end
  endtask : check

  function automatic logic [31:0] v12(input logic [7:0] nid, input logic [11:0] vb,
                                      input logic [7:0] pl);
    return {4'h0, nid, vb, pl};
  endfunction : v12

  function automatic logic [31:0] v4(input logic [7:0] nid, input logic [3:0] vb,
                                     input logic [15:0] pl);
    return {4'h0, nid, vb, pl};
  endfunction : v4

  task automatic link(input logic [31:0] w, input logic [31:0] exp);
    logic [31:0] r;
    bit ok;
    host.xfer(w, r, ok);
    if (!ok) begin
      num_errors++;
      $display("BAD %0t link handshake timed out", $time);
      finish_test();
    end
    check(r, exp);
  endtask : link

  task automatic rd_eq(input logic [6:0] a, input logic [15:0] exp);
    @(posedge mclk);
    eq_rd_addr <= a;
    repeat (2) @(posedge mclk);
    #1;
    check({16'h0000, eq_coef_data}, {16'h0000, exp});
  endtask : rd_eq

  // ----------------------------------------------------------------
  // Scenarios
  // ----------------------------------------------------------------
  task automatic t_reset;
    check({31'h0, eq_bypass}, 32'h1);
    check({31'h0, symmetric_coeff}, 32'h1);
    check({31'h0, spdif_src_adc}, 32'h0);
    link(v12(8'h03, `HDAVH_VERB_GET_PST, 8'h00), 32'h0);
    $display("test reset done");
  endtask : t_reset

  task automatic t_sdi;
    for (int n = 0; n < 5; n++) begin
      link(v12(n[7:0], `HDAVH_VERB_SET_SDI, 8'h01), 32'h0);
      link(v12(n[7:0], `HDAVH_VERB_GET_SDI, 8'h00), 32'h0);
    end
    $display("test sdi done");
  endtask : t_sdi

  task automatic t_afg;
    link(v4(8'h01, 4'h5, 16'h0005), 32'h0);
    link(v4(8'h01, 4'h4, 16'hbeef), 32'h0);
    link(v4(8'h01, 4'hd, 16'h0000), 32'h5);
    link(v4(8'h01, 4'hc, 16'h0000), 32'hbeef);
    link(v4(8'h01, 4'h5, 16'h0006), 32'h0);
    link(v4(8'h01, 4'hc, 16'h0000), 32'h0);
    link(v12(8'h01, `HDAVH_VERB_SET_PST, 8'h82), 32'h0);
    check({31'h0, eq_bypass}, 32'h1);
    link(v12(8'h01, `HDAVH_VERB_GET_PST, 8'h00), 32'h0);
    $display("test function group done");
  endtask : t_afg

  task automatic t_state;
    logic [7:0] st [6] = '{8'h00, 8'h01, 8'h02, 8'h80, 8'h81, 8'h82};
    logic [7:0] rb [6] = '{8'h00, 8'h02, 8'h02, 8'h80, 8'h82, 8'h82};
    for (int i = 0; i < 6; i++) begin
      link(v12(8'h03, `HDAVH_VERB_SET_PST, st[i]), 32'h0);
      link(v12(8'h03, `HDAVH_VERB_GET_PST, 8'h00), {24'h0, rb[i]});
      check({31'h0, eq_bypass}, {31'h0, st[i][6:0] == 7'h00});
      check({31'h0, symmetric_coeff}, {31'h0, ~st[i][7]});
    end
    $display("test state done");
  endtask : t_state

  task automatic t_coef;
    link(v12(8'h03, `HDAVH_VERB_SET_PST, 8'h00), 32'h0);
    link(v4(8'h03, 4'h5, 16'h0005), 32'h0);
    link(v4(8'h03, 4'h4, 16'h1234), 32'h0);
    rd_eq(7'h05, 16'h1234);
    rd_eq(7'h45, 16'h1234);
    link(v12(8'h03, `HDAVH_VERB_SET_PST, 8'h80), 32'h0);
    link(v4(8'h03, 4'h5, 16'h0047), 32'h0);
    link(v4(8'h03, 4'h4, 16'habcd), 32'h0);
    rd_eq(7'h47, 16'habcd);
    rd_eq(7'h07, 16'h0000);
    link(v4(8'h03, 4'hd, 16'h0000), 32'h47);
    link(v4(8'h03, 4'hc, 16'h0000), 32'habcd);
    link(v12(8'h03, `HDAVH_VERB_SET_PST, 8'h81), 32'h0);
    link(v4(8'h03, 4'h5, 16'h0047), 32'h0);
    link(v4(8'h03, 4'h4, 16'h5555), 32'h0);
    rd_eq(7'h47, 16'h5555);
    link(v12(8'h03, `HDAVH_VERB_SET_PST, 8'h00), 32'h0);
    $display("test coefficients done");
  endtask : t_coef

  task automatic t_hold;
    rd_eq(7'h45, 16'h1234);
    @(posedge mclk);
    ce <= 1'b0;
    eq_rd_addr <= 7'h47;
    repeat (3) @(posedge mclk);
    #1;
    check({16'h0000, eq_coef_data}, 32'h0000_1234);
    @(posedge mclk);
    ce <= 1'b1;
    rd_eq(7'h47, 16'h5555);
    $display("test clock enable done");
  endtask : t_hold

  task automatic t_other;
    link(v12(8'h02, `HDAVH_VERB_SET_CONN, 8'h01), 32'h0);
    check({31'h0, spdif_src_adc}, 32'h1);
    link(v12(8'h02, `HDAVH_VERB_GET_CONN, 8'h00), 32'h1);
    link(v12(8'h02, `HDAVH_VERB_SET_CONN, 8'h00), 32'h0);
    check({31'h0, spdif_src_adc}, 32'h0);
    link(v4(8'h04, 4'hc, 16'h0000), 32'h0);
    link(v4(8'h00, 4'hc, 16'h0000), 32'h0);
    link(v12(8'h05, `HDAVH_VERB_GET_PST, 8'h00), 32'h0);
    $display("test other nodes done");
  endtask : t_other

  // ----------------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------------
  initial begin
    rst_n = 1'b0;
    ce = 1'b1;
    eq_rd_addr = 7'h00;
    repeat (3) @(posedge mclk);
    rst_n <= 1'b1;
    t_reset();
    t_sdi();
    t_afg();
    t_state();
    t_coef();
    t_hold();
    t_other();
    finish_test();
  end
endmodule : tb_top
